// *** srsr_top.sv ***
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "srsr_consts.svh"
module srsr_top (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // instrument side
  input wire logic measuring_pin,
  input wire srsr_pkg::srsr_evt_t evt,
  output logic srq,
  output logic auto_cal,
  output logic cal_start
);
  import srsr_pkg::*;

  // ---------------------------------------------
  // bus slave
  // ---------------------------------------------
  srsr_aphase_t ap_reg;
  logic wr_pend_reg;
  logic ap_go;
  logic rd_go;
  logic [5:0] wa;
  logic wr_now;
  logic [15:0] wd;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ap_go = ce && hsel && htrans[1] && hready;
  assign rd_go = ap_go && !hwrite;
  assign wa = ap_reg.addr;
  assign wr_now = ce && wr_pend_reg;
  assign wd = hwdata[15:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_reg <= '0;
      wr_pend_reg <= 1'b0;
    end
    else if (ce)
    begin
      // only whole words; other sizes are accepted and ignored
      wr_pend_reg <= ap_go && hwrite && (hsize == 3'h2);
      ap_reg <= '{addr: {haddr[5:2], 2'h0}, write: hwrite};
    end
  end

  // ---------------------------------------------
  // control registers
  // ---------------------------------------------
  logic [7:0] sre_reg, ese_reg;
  logic [15:0] qen_reg, qptr_reg, qntr_reg;
  logic [15:0] oen_reg, optr_reg, ontr_reg;
  logic cmd_cls, cmd_preset, cmd_rst;

  assign cmd_cls = wr_now && wa == `SRSR_A_CMD && wd[`SRSR_CMD_CLS];
  assign cmd_preset = wr_now && wa == `SRSR_A_CMD && wd[`SRSR_CMD_PRESET];
  assign cmd_rst = wr_now && wa == `SRSR_A_CMD && wd[`SRSR_CMD_RST];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sre_reg <= 8'h00;
      ese_reg <= 8'h00;
    end
    else if (wr_now)
    begin
      if (wa == `SRSR_A_SRE)
        sre_reg <= wd[7:0] & `SRSR_RQS_MASK;
      if (wa == `SRSR_A_ESE)
        ese_reg <= wd[7:0];
    end
  end

  // preset opens positive filters, closes negative ones and enables
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      qen_reg <= 16'h0000;
      qptr_reg <= `SRSR_PTR_RST & `SRSR_QMASK;
      qntr_reg <= 16'h0000;
      oen_reg <= 16'h0000;
      optr_reg <= `SRSR_PTR_RST;
      ontr_reg <= 16'h0000;
    end
    else if (cmd_preset)
    begin
      qen_reg <= 16'h0000;
      qptr_reg <= `SRSR_PTR_RST & `SRSR_QMASK;
      qntr_reg <= 16'h0000;
      oen_reg <= 16'h0000;
      optr_reg <= `SRSR_PTR_RST;
      ontr_reg <= 16'h0000;
    end
    else if (wr_now)
    begin
      case (wa)
        `SRSR_A_QEN: qen_reg <= wd & `SRSR_QMASK; // see R16
        `SRSR_A_QPTR: qptr_reg <= wd & `SRSR_QMASK;
        `SRSR_A_QNTR: qntr_reg <= wd & `SRSR_QMASK;
        `SRSR_A_OEN: oen_reg <= wd;
        `SRSR_A_OPTR: optr_reg <= wd;
        `SRSR_A_ONTR: ontr_reg <= wd;
        default: ;
      endcase
    end
  end

  // reset command brings calibration back to its default
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      auto_cal <= 1'b1;
    else if (cmd_rst)
      auto_cal <= 1'b1; // see R7
    else if (wr_now && wa == `SRSR_A_CTRL)
      auto_cal <= wd[0]; // see R7
  end

  // ---------------------------------------------
  // measuring input and calibration request
  // ---------------------------------------------
  logic m1_reg, m2_reg, m3_reg, meas_reg, meas_prev_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      m1_reg <= 1'b0;
      m2_reg <= 1'b0;
      m3_reg <= 1'b0;
      meas_reg <= 1'b0;
    end
    else if (ce)
    begin
      m1_reg <= measuring_pin;
      m2_reg <= m1_reg;
      m3_reg <= m2_reg;
      if (m2_reg == m3_reg)
        meas_reg <= m3_reg;
    end
  end

  // with calibration off the stored values are simply reused
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meas_prev_reg <= 1'b0;
      cal_start <= 1'b0;
    end
    else if (ce)
    begin
      meas_prev_reg <= meas_reg;
      cal_start <= auto_cal && meas_reg && !meas_prev_reg; // see R7
    end
  end

  // ---------------------------------------------
  // conditions, transition filters, events
  // ---------------------------------------------
  logic [15:0] qcond, ocond, qprev_reg, oprev_reg;
  logic [15:0] qevt_reg, oevt_reg, qdirect;
  logic [7:0] esr_reg;
  logic clr_q, clr_o, clr_e;

  function automatic logic [15:0] filt(input logic [15:0] c,
      input logic [15:0] p, input logic [15:0] pt, input logic [15:0] nt);
    filt = (c & ~p & pt) | (~c & p & nt);
  endfunction

  assign qcond = auto_cal ? 16'h0000 : `SRSR_QCAL_BITS; // see R8
  assign ocond = {11'h000, meas_reg, 4'h0}; // see R11
  assign qdirect = ({15'h0000, evt.cal_err} << `SRSR_B_CALERR)
      | ({15'h0000, evt.oolim} << `SRSR_B_OOLIM)
      | ({15'h0000, evt.cmd_warn} << `SRSR_B_CMDWARN); // see R15
  // reading an event register empties it, as does clear status
  assign clr_q = cmd_cls || (rd_go && haddr[5:0] == `SRSR_A_QEVT);
  assign clr_o = cmd_cls || (rd_go && haddr[5:0] == `SRSR_A_OEVT);
  assign clr_e = cmd_cls || (rd_go && haddr[5:0] == `SRSR_A_ESR);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      qprev_reg <= 16'h0000;
      oprev_reg <= 16'h0000;
    end
    else if (ce)
    begin
      qprev_reg <= qcond;
      oprev_reg <= ocond;
    end
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      qevt_reg <= 16'h0000;
      oevt_reg <= 16'h0000;
      esr_reg <= 8'h00;
    end
    else if (ce)
    begin
      qevt_reg <= ((clr_q ? 16'h0000 : qevt_reg)
          | filt(qcond, qprev_reg, qptr_reg, qntr_reg) // see R9
          | qdirect) & `SRSR_QMASK; // see R15, R16
      oevt_reg <= (clr_o ? 16'h0000 : oevt_reg)
          | filt(ocond, oprev_reg, optr_reg, ontr_reg); // see R12
      esr_reg <= (clr_e ? 8'h00 : esr_reg)
          | ({7'h00, evt.cmd_err} << `SRSR_B_CMDERR); // see R3
    end
  end

  // ---------------------------------------------
  // status byte and service request
  // ---------------------------------------------
  logic [7:0] sum, stb;
  logic rqs;

  always_comb
  begin
    sum = 8'h00;
    sum[`SRSR_B_QSUM] = |(qevt_reg & qen_reg); // see R1, R10
    sum[`SRSR_B_ESB] = |(esr_reg & ese_reg); // see R1, R4
    sum[`SRSR_B_OSUM] = |(oevt_reg & oen_reg); // see R1, R13
  end

  assign rqs = |(sum & sre_reg & `SRSR_RQS_MASK); // see R17
  assign stb = sum | ({7'h00, rqs} << `SRSR_B_RQS); // see R6

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      srq <= 1'b0;
    else if (ce)
      srq <= rqs; // see R2, R5
  end

  // ---------------------------------------------
  // read data, captured in the address phase
  // ---------------------------------------------
  logic [15:0] rd_mux;

  always_comb
  begin
    case (haddr[5:0])
      `SRSR_A_CTRL: rd_mux = {15'h0000, auto_cal};
      `SRSR_A_STB: rd_mux = {8'h00, stb};
      `SRSR_A_SRE: rd_mux = {8'h00, sre_reg};
      `SRSR_A_ESR: rd_mux = {8'h00, esr_reg};
      `SRSR_A_ESE: rd_mux = {8'h00, ese_reg};
      `SRSR_A_QCOND: rd_mux = qcond;
      `SRSR_A_QEVT: rd_mux = qevt_reg;
      `SRSR_A_QEN: rd_mux = qen_reg;
      `SRSR_A_QPTR: rd_mux = qptr_reg;
      `SRSR_A_QNTR: rd_mux = qntr_reg;
      `SRSR_A_OCOND: rd_mux = ocond;
      `SRSR_A_OEVT: rd_mux = oevt_reg;
      `SRSR_A_OEN: rd_mux = oen_reg;
      `SRSR_A_OPTR: rd_mux = optr_reg;
      `SRSR_A_ONTR: rd_mux = ontr_reg;
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (rd_go)
      hrdata <= {16'h0000, rd_mux};
  end

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_meas_fall;
    ce && ontr_reg[`SRSR_B_MEAS] && oprev_reg[`SRSR_B_MEAS]
        && !ocond[`SRSR_B_MEAS];
  endsequence

  sequence s_cal_off;
    ce && qptr_reg == 16'h0064 && qcond[2] && !qprev_reg[2];
  endsequence

  a_cmd_err_set: assert property (ce && evt.cmd_err |=> esr_reg[5]) // see R3
    else $error("command error not latched");
  a_esb_pass: assert property (ese_reg == 8'h20 && esr_reg[5] |-> stb[5]) // see R4
    else $error("event summary missing");
  a_srq_raise: assert property (ce && sre_reg == 8'h20 && stb[5] |=> srq) // see R5
    else $error("service request not raised");
  a_poll_96: assert property (ese_reg == 8'h20 && sre_reg == 8'h20
      && esr_reg == 8'h20 && qen_reg == 0 && oen_reg == 0
      |-> stb == 8'h60) // see R6
    else $error("poll value not 96");
  a_cal_held: assert property (!auto_cal |-> qcond[2] && qcond[5]
      && qcond[6]) // see R8
    else $error("calibration bits not held");
  a_ques_rise: assert property (s_cal_off |=> qevt_reg[2]) // see R9
    else $error("rising change not latched");
  a_poll_72: assert property (s_cal_off ##0 qen_reg == 16'h0064
      && sre_reg == 8'h08 && ese_reg == 0 && oen_reg == 0
      |=> stb == 8'h48 ##1 srq) // see R10
    else $error("poll value not 72");
  a_meas_bit: assert property (ce && $changed(m3_reg) ##1 ce && !$changed(m3_reg)
      |=> ocond[4] == $past(m3_reg)) // see R11
    else $error("measuring bit wrong");
  a_oper_fall: assert property (s_meas_fall |=> oevt_reg[4]) // see R12
    else $error("measuring fall not latched");
  a_poll_192: assert property (s_meas_fall ##0 oen_reg == 16'h0010
      && sre_reg == 8'h80 && ese_reg == 0 && qen_reg == 0
      |=> stb == 8'hC0) // see R13
    else $error("poll value not 192");
  a_direct_evt: assert property (ce && evt.cal_err |=> qevt_reg[8]) // see R15
    else $error("event bit filtered");
  a_ques_b15: assert property (!qevt_reg[15] && !qptr_reg[15]) // see R16
    else $error("bit 15 set");
  a_rqs_line: assert property (ce && |(sum & sre_reg) |=> srq) // see R17
    else $error("request line not driven");
endmodule
`default_nettype wire

// *** srsr_consts.svh ***
// Contract
// R1: three groups each feed status byte summary
// R2: status byte drives service-request line
// R3: bad command sets event bit 5
// R4: event mask 32 passes command error
// R5: request mask 32 raises line on summary
// R6: poll after command error reads 96
// R7: auto calibration default; off reuses values
// R8: calibration off holds bits 2,5,6 true
// R9: mask 100/0 latches rising changes only
// R10: masks 100 and 8 give poll 72
// R11: operation bit 4 true while measuring
// R12: masks 0/16 latch measuring fall only
// R13: masks 16 and 128 give poll 192
// R14: host clears and presets before configuring
// R15: event bits bypass transition filters
// R16: questionable bit 15 always zero
// R17: request bit 6 from masked summaries
`ifndef SRSR_CONSTS_SVH
`define SRSR_CONSTS_SVH
// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define SRSR_A_CTRL 6'h00
`define SRSR_A_CMD 6'h04
`define SRSR_A_STB 6'h08
`define SRSR_A_SRE 6'h0C
`define SRSR_A_ESR 6'h10
`define SRSR_A_ESE 6'h14
`define SRSR_A_QCOND 6'h18
`define SRSR_A_QEVT 6'h1C
`define SRSR_A_QEN 6'h20
`define SRSR_A_QPTR 6'h24
`define SRSR_A_QNTR 6'h28
`define SRSR_A_OCOND 6'h2C
`define SRSR_A_OEVT 6'h30
`define SRSR_A_OEN 6'h34
`define SRSR_A_OPTR 6'h38
`define SRSR_A_ONTR 6'h3C
// ---------------------------------------------
// field positions
// ---------------------------------------------
`define SRSR_B_CMDERR 5
`define SRSR_B_CALERR 8
`define SRSR_B_OOLIM 10
`define SRSR_B_CMDWARN 14
`define SRSR_B_MEAS 4
`define SRSR_B_QSUM 3
`define SRSR_B_ESB 5
`define SRSR_B_RQS 6
`define SRSR_B_OSUM 7
`define SRSR_CMD_CLS 0
`define SRSR_CMD_PRESET 1
`define SRSR_CMD_RST 2
// ---------------------------------------------
// fixed values
// ---------------------------------------------
`define SRSR_QCAL_BITS 16'h0064
`define SRSR_QMASK 16'h7FFF
`define SRSR_PTR_RST 16'hFFFF
`define SRSR_RQS_MASK 8'hBF
`endif

// *** srsr_pkg.sv ***
package srsr_pkg;
  // instrument event pulses, one hclk cycle each
  typedef struct packed {
    logic cmd_err;
    logic cal_err;
    logic oolim;
    logic cmd_warn;
  } srsr_evt_t;
  typedef struct packed {
    logic [5:0] addr;
    logic write;
  } srsr_aphase_t;
endpackage

// *** srsr_inst_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module srsr_inst_model (
  // clock
  input wire logic hclk,
  // instrument side towards the block
  output var srsr_pkg::srsr_evt_t evt,
  output var logic measuring_pin
);
  import srsr_pkg::*;
  // -------------------------------------------
  // event pulses and measuring level
  // -------------------------------------------
  initial
  begin
    evt = '0;
    measuring_pin = 1'b0;
  end
  // one clock wide, as the block samples events on every edge with ce high
  task automatic pulse(input srsr_evt_t e);
    @(posedge hclk);
    evt <= e;
    @(posedge hclk);
    evt <= '0;
  endtask
  // level held for the whole measurement
  task automatic meas(input logic m);
    @(posedge hclk);
    measuring_pin <= m;
  endtask
endmodule
`default_nettype wire

// *** test_status_reporting_service_request.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "srsr_consts.svh"
module test_status_reporting_service_request;
  import srsr_pkg::*;
  logic hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp;
  logic srq, auto_cal, cal_start, measuring_pin;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  srsr_evt_t evt;
  int miscompares = 0;
  int total_checks = 0;
  int cal_starts = 0;
  logic [5:0] ra [7];
  logic [31:0] rv [7];
  srsr_top srsr_top_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .measuring_pin(measuring_pin),
    .evt(evt), .srq(srq), .auto_cal(auto_cal), .cal_start(cal_start));
  srsr_inst_model srsr_inst_model_inst (.hclk(hclk), .evt(evt),
    .measuring_pin(measuring_pin));
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk)
    if (cal_start === 1'b1)
      cal_starts <= cal_starts + 1;
  // -------------------------------------------
  // checking and bus tasks
  // -------------------------------------------
  task automatic stop_test;
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
  endtask
  // single word transfer; read data taken at the data phase edge
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {26'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [5:0] a,
                     input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask
  task automatic wait_srq(input logic lvl);
    int n;
    for (n = 0; n < 20 && srq !== lvl; n++)
      @(posedge hclk);
    chk("srq level", {31'h0, srq}, {31'h0, lvl});
    if (srq !== lvl)
      stop_test();
  endtask
  // -------------------------------------------
  // main sequence
  // -------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ra = '{`SRSR_A_CTRL, `SRSR_A_SRE, `SRSR_A_ESE, `SRSR_A_QPTR,
           `SRSR_A_OPTR, `SRSR_A_QNTR, `SRSR_A_ONTR};
    rv = '{32'h1, 32'h0, 32'h0, 32'h7FFF, 32'hFFFF, 32'h0, 32'h0};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 7; i++)
      rdc("reset value", ra[i], rv[i]);
    chk("hresp okay", {31'h0, hresp}, 32'h0);
    wr(`SRSR_A_STB, 32'hFF);
    rdc("stb read only", `SRSR_A_STB, 32'h0);
    rdc("cmd reads zero", `SRSR_A_CMD, 32'h0);
    // host start-up order: clear, preset and reset in one command, then zero enables
    wr(`SRSR_A_CMD, 32'h7);
    wr(`SRSR_A_SRE, 32'h0);
    wr(`SRSR_A_ESE, 32'h0);
    // command error without event enable: no summary
    srsr_inst_model_inst.pulse(srsr_evt_t'(4'h8));
    repeat (3) @(posedge hclk);
    rdc("stb masked", `SRSR_A_STB, 32'h0);
    rdc("esr latched", `SRSR_A_ESR, 32'h20);
    wr(`SRSR_A_ESE, 32'h20);
    wr(`SRSR_A_SRE, 32'h20);
    srsr_inst_model_inst.pulse(srsr_evt_t'(4'h8));
    wait_srq(1'b1);
    rdc("poll cmd error", `SRSR_A_STB, 32'h60);
    rdc("esr bit 5", `SRSR_A_ESR, 32'h20);
    rdc("esr cleared", `SRSR_A_ESR, 32'h0);
    wait_srq(1'b0);
    // clock enable low: an event pulse must not be latched
    ce <= 1'b0;
    srsr_inst_model_inst.pulse(srsr_evt_t'(4'h8));
    ce <= 1'b1;
    rdc("frozen by ce", `SRSR_A_ESR, 32'h0);
    // calibration off raises questionable conditions
    wr(`SRSR_A_CMD, 32'h1);
    wr(`SRSR_A_ESE, 32'h0);
    wr(`SRSR_A_QPTR, 32'h64);
    wr(`SRSR_A_QNTR, 32'h0);
    wr(`SRSR_A_QEN, 32'h64);
    wr(`SRSR_A_SRE, 32'h8);
    wr(`SRSR_A_CTRL, 32'h0);
    rdc("qcond cal off", `SRSR_A_QCOND, 32'h64);
    chk("auto cal off", {31'h0, auto_cal}, 32'h0);
    wait_srq(1'b1);
    rdc("poll cal off", `SRSR_A_STB, 32'h48);
    rdc("qevt rising", `SRSR_A_QEVT, 32'h64);
    wr(`SRSR_A_CTRL, 32'h1);
    rdc("qcond cal on", `SRSR_A_QCOND, 32'h0);
    rdc("qevt no fall", `SRSR_A_QEVT, 32'h0);
    wr(`SRSR_A_QPTR, 32'hFFFFFFFF);
    rdc("qptr bit 15", `SRSR_A_QPTR, 32'h7FFF);
    // event bits pass with the filters shut
    wr(`SRSR_A_QPTR, 32'h0);
    srsr_inst_model_inst.pulse(srsr_evt_t'(4'h7));
    rdc("qevt events", `SRSR_A_QEVT, 32'h4500);
    // measurement completion via the falling filter
    wr(`SRSR_A_CMD, 32'h3);
    wr(`SRSR_A_OPTR, 32'h0);
    wr(`SRSR_A_ONTR, 32'h10);
    wr(`SRSR_A_OEN, 32'h10);
    wr(`SRSR_A_SRE, 32'h80);
    srsr_inst_model_inst.meas(1'b1);
    repeat (8) @(posedge hclk);
    chk("cal per measurement", cal_starts, 32'd1);
    rdc("ocond measuring", `SRSR_A_OCOND, 32'h10);
    rdc("oevt no rise", `SRSR_A_OEVT, 32'h0);
    chk("srq idle", {31'h0, srq}, 32'h0);
    srsr_inst_model_inst.meas(1'b0);
    wait_srq(1'b1);
    rdc("poll done", `SRSR_A_STB, 32'hC0);
    rdc("oevt fall", `SRSR_A_OEVT, 32'h10);
    // stored calibration reused: no new start
    wr(`SRSR_A_CTRL, 32'h0);
    srsr_inst_model_inst.meas(1'b1);
    repeat (8) @(posedge hclk);
    chk("no cal when off", cal_starts, 32'd1);
    stop_test();
  end
endmodule
`default_nettype wire
